// *** hdl/ipsb_pkg.sv ***
// Package for the interrupt priority select bank: offsets, masks, reset values
package ipsb_pkg;
  localparam int ipsb_addr_w = 12;
  localparam logic [11:0] ipsb_off_prio4 = 12'h000;
  localparam logic [11:0] ipsb_off_prio5 = 12'h004;
  localparam logic [11:0] ipsb_off_prio6 = 12'h008;
  localparam logic [11:0] ipsb_off_prio7 = 12'h00c;
  localparam logic [11:0] ipsb_off_prio8 = 12'h010;
  localparam logic [11:0] ipsb_off_prio9 = 12'h014;
  localparam logic [11:0] ipsb_off_prio10 = 12'h018;
  localparam logic [11:0] ipsb_off_base_upper = 12'h01c;
  localparam logic [11:0] ipsb_off_lock = 12'h020;
  // Implemented bit masks
  localparam logic [7:0] ipsb_mask_prio4 = 8'hef;
  localparam logic [7:0] ipsb_mask_prio5 = 8'hff;
  localparam logic [7:0] ipsb_mask_prio6 = 8'hff;
  localparam logic [7:0] ipsb_mask_prio7 = 8'h3b;
  localparam logic [7:0] ipsb_mask_prio8 = 8'hc0;
  localparam logic [7:0] ipsb_mask_prio9 = 8'h0f;
  localparam logic [7:0] ipsb_mask_prio10 = 8'h03;
  localparam logic [7:0] ipsb_mask_base_upper = 8'h1f;
  localparam logic [7:0] ipsb_mask_lock = 8'h01;
  // Values after reset
  localparam logic [7:0] ipsb_rst_prio4 = 8'hef;
  localparam logic [7:0] ipsb_rst_prio5 = 8'hff;
  localparam logic [7:0] ipsb_rst_prio6 = 8'hff;
  localparam logic [7:0] ipsb_rst_prio7 = 8'h3b;
  localparam logic [7:0] ipsb_rst_prio8 = 8'hc0;
  localparam logic [7:0] ipsb_rst_prio9 = 8'h0f;
  localparam logic [7:0] ipsb_rst_prio10 = 8'h00;
  localparam logic [7:0] ipsb_rst_base_upper = 8'h00;
  localparam logic [7:0] ipsb_rst_lock = 8'h00;
  typedef struct packed {
    logic [7:0] prio4;
    logic [7:0] prio5;
    logic [7:0] prio6;
    logic [7:0] prio7;
    logic [7:0] prio8;
    logic [7:0] prio9;
    logic [7:0] prio10;
    logic [7:0] base_upper;
    logic lock;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ipsb_state_s;
endpackage

// *** hdl/ipsb_bank.sv ***
// Interrupt priority select bank with APB register access
// What this block does
// RQ1 - A priority bit of one sends its source high, zero sends it low
// RQ2 - Priority bits of registers 4 to 9 are read/write and reset to one
// RQ3 - Register 10's two bits are read/write and reset to zero
// RQ4 - Unimplemented bits in priority and upper base registers read zero
// RQ5 - Register 4: logic cell1, waveform1, oscillator1, bit4 empty, ccp1, tmr2, tmr1g, tmr1
// RQ6 - Register 5: twowire2 tx/rx, dma2 abort/overrun/dest/src, comparator2, ext input1
// RQ7 - Register 6: timer3 gate/timer3, serial2 general/err/tx/rx, twowire2 err/general
// RQ8 - Register 7: bits 7-6 and 2 empty; ext2, logic2, waveform2, ccp2, timer4
// RQ9 - Register 8: only timer5 gate and timer5 in bits 7 and 6
// RQ10 - Register 9: bits 7-4 empty; logic3, waveform3, ccp3, timer6
// RQ11 - Register 10: logic cell4 in bit 1, capture/compare4 in bit 0
// RQ12 - Upper base register holds base address bits 20-16, read/write, reset zero
// RQ13 - Writes to the base register are ignored while the lock bit is set
// RQ14 - Priority bits drive the arbiter continuously, effective right after the write
`timescale 1ns/1ps
`default_nettype none
module ipsb_bank
  import ipsb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ipsb_addr_w-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic logic_cell1_prio,
  output logic waveform_gen1_prio,
  output logic oscillator1_prio,
  output logic capture_compare1_prio,
  output logic timer2_prio,
  output logic timer1_gate_prio,
  output logic timer1_prio,
  output logic twowire2_tx_prio,
  output logic twowire2_rx_prio,
  output logic dma2_abort_prio,
  output logic dma2_overrun_prio,
  output logic dma2_dest_count_prio,
  output logic dma2_src_count_prio,
  output logic comparator2_prio,
  output logic ext_input1_prio,
  output logic timer3_gate_prio,
  output logic timer3_prio,
  output logic serial2_general_prio,
  output logic serial2_framing_err_prio,
  output logic serial2_tx_prio,
  output logic serial2_rx_prio,
  output logic twowire2_error_prio,
  output logic twowire2_general_prio,
  output logic ext_input2_prio,
  output logic logic_cell2_prio,
  output logic waveform_gen2_prio,
  output logic capture_compare2_prio,
  output logic timer4_prio,
  output logic timer5_gate_prio,
  output logic timer5_prio,
  output logic logic_cell3_prio,
  output logic waveform_gen3_prio,
  output logic capture_compare3_prio,
  output logic timer6_prio,
  output logic logic_cell4_prio,
  output logic capture_compare4_prio,
  output logic [4:0] vector_base_upper,
  output logic vector_table_lock_bit
);

  ipsb_state_s r;
  ipsb_state_s next_r;
  logic wr_go;
  logic rd_go;
  logic hit;
  logic [7:0] wbyte;
  logic [7:0] rbyte;

  always_comb begin
    next_r = r;
    // Zero-wait slave: answer in the access cycle itself
    next_r.pready = psel && !penable;
    next_r.pslverr = 1'b0;
    wr_go = psel && !penable && pwrite && pstrb[0];
    rd_go = psel && !penable && !pwrite;
    wbyte = pwdata[7:0];
    hit = 1'b1;
    rbyte = 8'h00;
    // Masking on write keeps unimplemented bits at zero
    case (paddr)
      ipsb_off_prio4: begin
        rbyte = r.prio4; // RQ4
        if (wr_go) next_r.prio4 = wbyte & ipsb_mask_prio4; // RQ2 RQ5
      end
      ipsb_off_prio5: begin
        rbyte = r.prio5;
        if (wr_go) next_r.prio5 = wbyte & ipsb_mask_prio5; // RQ2 RQ6
      end
      ipsb_off_prio6: begin
        rbyte = r.prio6;
        if (wr_go) next_r.prio6 = wbyte & ipsb_mask_prio6; // RQ2 RQ7
      end
      ipsb_off_prio7: begin
        rbyte = r.prio7;
        if (wr_go) next_r.prio7 = wbyte & ipsb_mask_prio7; // RQ2 RQ8
      end
      ipsb_off_prio8: begin
        rbyte = r.prio8;
        if (wr_go) next_r.prio8 = wbyte & ipsb_mask_prio8; // RQ2 RQ9
      end
      ipsb_off_prio9: begin
        rbyte = r.prio9;
        if (wr_go) next_r.prio9 = wbyte & ipsb_mask_prio9; // RQ2 RQ10
      end
      ipsb_off_prio10: begin
        rbyte = r.prio10;
        if (wr_go) next_r.prio10 = wbyte & ipsb_mask_prio10; // RQ3 RQ11
      end
      ipsb_off_base_upper: begin
        rbyte = r.base_upper; // RQ4
        if (wr_go && !r.lock) next_r.base_upper = wbyte & ipsb_mask_base_upper; // RQ12 RQ13
      end
      ipsb_off_lock: begin
        rbyte = {7'h00, r.lock};
        // Unlock sequence is outside this bank; software writes the bit directly
        if (wr_go) next_r.lock = wbyte[0];
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    if (psel && !penable) begin
      next_r.pslverr = !hit;
      next_r.prdata = (rd_go && hit) ? {24'h000000, rbyte} : 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r.prio4 <= ipsb_rst_prio4; // RQ2
      r.prio5 <= ipsb_rst_prio5;
      r.prio6 <= ipsb_rst_prio6;
      r.prio7 <= ipsb_rst_prio7;
      r.prio8 <= ipsb_rst_prio8;
      r.prio9 <= ipsb_rst_prio9;
      r.prio10 <= ipsb_rst_prio10; // RQ3
      r.base_upper <= ipsb_rst_base_upper; // RQ12
      r.lock <= ipsb_rst_lock[0];
      r.prdata <= 32'h00000000;
      r.pready <= 1'b0;
      r.pslverr <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  // Straight from the flops so the arbiter sees a new value the cycle after the write
  assign logic_cell1_prio = r.prio4[7]; // RQ1 RQ14
  assign waveform_gen1_prio = r.prio4[6];
  assign oscillator1_prio = r.prio4[5];
  assign capture_compare1_prio = r.prio4[3];
  assign timer2_prio = r.prio4[2];
  assign timer1_gate_prio = r.prio4[1];
  assign timer1_prio = r.prio4[0];
  assign twowire2_tx_prio = r.prio5[7];
  assign twowire2_rx_prio = r.prio5[6];
  assign dma2_abort_prio = r.prio5[5];
  assign dma2_overrun_prio = r.prio5[4];
  assign dma2_dest_count_prio = r.prio5[3];
  assign dma2_src_count_prio = r.prio5[2];
  assign comparator2_prio = r.prio5[1];
  assign ext_input1_prio = r.prio5[0];
  assign timer3_gate_prio = r.prio6[7];
  assign timer3_prio = r.prio6[6];
  assign serial2_general_prio = r.prio6[5];
  assign serial2_framing_err_prio = r.prio6[4];
  assign serial2_tx_prio = r.prio6[3];
  assign serial2_rx_prio = r.prio6[2];
  assign twowire2_error_prio = r.prio6[1];
  assign twowire2_general_prio = r.prio6[0];
  assign ext_input2_prio = r.prio7[5];
  assign logic_cell2_prio = r.prio7[4];
  assign waveform_gen2_prio = r.prio7[3];
  assign capture_compare2_prio = r.prio7[1];
  assign timer4_prio = r.prio7[0];
  assign timer5_gate_prio = r.prio8[7];
  assign timer5_prio = r.prio8[6];
  assign logic_cell3_prio = r.prio9[3];
  assign waveform_gen3_prio = r.prio9[2];
  assign capture_compare3_prio = r.prio9[1];
  assign timer6_prio = r.prio9[0];
  assign logic_cell4_prio = r.prio10[1];
  assign capture_compare4_prio = r.prio10[0];
  assign vector_base_upper = r.base_upper[4:0];
  assign vector_table_lock_bit = r.lock;

endmodule
`default_nettype wire

// *** sim/ipsb_asserts.sv ***
// Checker for the priority select bank
`timescale 1ns/1ps
`default_nettype none
module ipsb_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic timer1_prio,
  input wire logic logic_cell1_prio,
  input wire logic logic_cell4_prio,
  input wire logic capture_compare4_prio,
  input wire logic [4:0] vector_base_upper,
  input wire logic vector_table_lock_bit
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Strobe-qualified setup write; the bank applies it at the setup edge
  logic wr;
  assign wr = psel && !penable && pwrite && pstrb[0];
  AST_ZERO_WAIT: assert property (psel && !penable |=> pready)
    else $error("access not answered");
  AST_RESET_VAL: assert property ($rose(presetn) |-> timer1_prio && !capture_compare4_prio)
    else $error("wrong value after reset");
  AST_P4_WR: assert property (wr && paddr == 12'h000 |=> timer1_prio == $past(pwdata[0])
    && logic_cell1_prio == $past(pwdata[7])) else $error("register 4 output wrong");
  AST_P10_WR: assert property (wr && paddr == 12'h018
    |=> {logic_cell4_prio, capture_compare4_prio} == $past(pwdata[1:0])) else $error("reg 10 out");
  AST_BASE_WR: assert property (wr && paddr == 12'h01c && !vector_table_lock_bit
    |=> vector_base_upper == $past(pwdata[4:0])) else $error("base write lost");
  AST_BASE_LOCK: assert property (wr && paddr == 12'h01c && vector_table_lock_bit
    |=> $stable(vector_base_upper)) else $error("locked base changed");
  AST_BASE_HOLD: assert property (!(wr && paddr == 12'h01c) |=> $stable(vector_base_upper))
    else $error("base changed without write");
  AST_RD_BASE: assert property (pready && !pwrite && paddr == 12'h01c
    |-> prdata == {27'h0, vector_base_upper}) else $error("base read wrong");
  cover property (wr && paddr == 12'h01c && vector_table_lock_bit);
  cover property (wr && paddr == 12'h018);
  cover property (pready && !pwrite && paddr == 12'h01c);
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking bench for the priority select bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, errv;
  logic timer1_prio, logic_cell1_prio, logic_cell4_prio, capture_compare4_prio;
  logic vector_table_lock_bit;
  logic [4:0] vector_base_upper;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [3:0] pstrb;
  logic [7:0] dv;
  // Every priority line not already watched by name lands in one word for comparison
  wire [31:0] po;
  int miscompares, num_checks, cyc;
  logic [7:0] rv [8] = '{8'hef, 8'hff, 8'hff, 8'h3b, 8'hc0, 8'h0f, 8'h00, 8'h00};
  logic [7:0] mk [8] = '{8'hef, 8'hff, 8'hff, 8'h3b, 8'hc0, 8'h0f, 8'h03, 8'h1f};
  ipsb_bank dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .logic_cell1_prio, .waveform_gen1_prio(po[0]), .oscillator1_prio(po[1]),
    .capture_compare1_prio(po[2]), .timer2_prio(po[3]), .timer1_gate_prio(po[4]), .timer1_prio,
    .twowire2_tx_prio(po[5]), .twowire2_rx_prio(po[6]), .dma2_abort_prio(po[7]),
    .dma2_overrun_prio(po[8]), .dma2_dest_count_prio(po[9]), .dma2_src_count_prio(po[10]),
    .comparator2_prio(po[11]), .ext_input1_prio(po[12]), .timer3_gate_prio(po[13]),
    .timer3_prio(po[14]), .serial2_general_prio(po[15]), .serial2_framing_err_prio(po[16]),
    .serial2_tx_prio(po[17]), .serial2_rx_prio(po[18]), .twowire2_error_prio(po[19]),
    .twowire2_general_prio(po[20]), .ext_input2_prio(po[21]), .logic_cell2_prio(po[22]),
    .waveform_gen2_prio(po[23]), .capture_compare2_prio(po[24]), .timer4_prio(po[25]),
    .timer5_gate_prio(po[26]), .timer5_prio(po[27]), .logic_cell3_prio(po[28]),
    .waveform_gen3_prio(po[29]), .capture_compare3_prio(po[30]), .timer6_prio(po[31]),
    .logic_cell4_prio,
    .capture_compare4_prio, .vector_base_upper, .vector_table_lock_bit);
  task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  // One edge of idle first, so back-to-back calls never drive psel twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n == 50) miscompares++;
    rdv = prdata;
    errv = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'h0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 8; i++) begin
      apb(1'h0, 12'(i * 4), 8'h00);
      chk("reset value", rdv, {24'h0, rv[i]});
    end
    chk("prio reset", po, 32'hffffffff);
    $display("reset test done");
    for (int j = 0; j < 2; j++) begin
      dv = j ? 8'h00 : 8'hff;
      for (int i = 0; i < 8; i++) apb(1'h1, 12'(i * 4), dv);
      for (int i = 0; i < 8; i++) begin
        apb(1'h0, 12'(i * 4), 8'h00);
        chk("readback", rdv, {24'h0, mk[i] & dv});
      end
      chk("prio out", {logic_cell1_prio, timer1_prio, logic_cell4_prio, capture_compare4_prio},
        {4{dv[0]}});
      chk("all prio", po, {32{dv[0]}});
      chk("base out", {27'h0, vector_base_upper}, {27'h0, dv[4:0]});
    end
    $display("read write test done");
    apb(1'h1, 12'h020, 8'h01);
    chk("lock out", {31'h0, vector_table_lock_bit}, 32'h1);
    apb(1'h1, 12'h01c, 8'h15);
    apb(1'h0, 12'h01c, 8'h00);
    chk("locked base", rdv, 32'h0);
    apb(1'h1, 12'h020, 8'h00);
    apb(1'h1, 12'h01c, 8'h15);
    apb(1'h0, 12'h01c, 8'h00);
    chk("unlocked base", rdv, 32'h15);
    $display("lock test done");
    pstrb <= 4'h0;
    apb(1'h1, 12'h01c, 8'h0a);
    pstrb <= 4'hf;
    apb(1'h0, 12'h01c, 8'h00);
    chk("no strobe", rdv, 32'h15);
    apb(1'h0, 12'h040, 8'h00);
    chk("unmapped err", {31'h0, errv}, 32'h1);
    chk("unmapped data", rdv, 32'h0);
    $display("refusal test done");
    wrap_up();
  end
endmodule
bind ipsb_bank ipsb_asserts u_asserts (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .prdata, .pready, .timer1_prio, .logic_cell1_prio, .logic_cell4_prio,
  .capture_compare4_prio, .vector_base_upper, .vector_table_lock_bit);
`default_nettype wire
